/* matrix_driver_common_config_regs.svh */
// Constants for the common configuration word of the matrix driver
// Behaviour
// [R1] Device count field is devices minus one
// [R2] Bit 8 enables pre-discharge, default on
// [R3] Bit 12 enables power saving, default off
// [R4] Bits 14-13 select extended power saving level
// [R5] Bit 15 enables open-load LED removal
// [R6] Scan line field is lines minus one
// [R7] Sub-periods equal sixteen times code plus one
// [R8] Bit 28 selects high or low multiplier range
// [R9] Multiplier factor is field plus one
// [R10] Red group delay in forward mode only
// [R11] Green group delay in forward mode only
// [R12] Blue group delay in forward mode only
// [R13] Bit 47 enables short caterpillar removal
// [R14] Soft reset command restores register defaults
// [R15] Line counter wraps after configured scan lines
// [R16] Reserved bits read fixed values, ignore writes
`ifndef MATRIX_DRIVER_COMMON_CONFIG_REGS_SVH
`define MATRIX_DRIVER_COMMON_CONFIG_REGS_SVH

`define CFG_WORD_WIDTH        48
`define CFG_CMD_WIDTH         16
`define CFG_CMD_WRITE         16'hAA00
`define CFG_CMD_READ          16'hAA60
`define CFG_CMD_SOFT_RESET    16'hAA80

`define CFG_RESET_VALUE       48'h2000_E000_0107
`define CFG_WRITE_MASK        48'h9FF1_F1FF_F11F

`define CFG_DEVICE_LSB        0
`define CFG_DEVICE_MSB        4
`define CFG_PREDISCHARGE_BIT  8
`define CFG_POWER_SAVE_BIT    12
`define CFG_EXT_PS_LSB        13
`define CFG_EXT_PS_MSB        14
`define CFG_OPEN_RM_BIT       15
`define CFG_SCAN_LSB          16
`define CFG_SCAN_MSB          21
`define CFG_SUBP_LSB          22
`define CFG_SUBP_MSB          24
`define CFG_RANGE_BIT         28
`define CFG_FACTOR_LSB        29
`define CFG_FACTOR_MSB        32
`define CFG_RED_DLY_LSB       36
`define CFG_RED_DLY_MSB       38
`define CFG_GREEN_DLY_LSB     39
`define CFG_GREEN_DLY_MSB     41
`define CFG_BLUE_DLY_LSB      42
`define CFG_BLUE_DLY_MSB      44
`define CFG_SHORT_RM_BIT      47

`define CFG_SUBP_STEP         8'h10
`define CFG_CHANNELS_PER_LINE 16

`endif

/* matrix_driver_pkg.sv */
// Types and decode functions shared by the configuration block
package matrix_driver_pkg;

	typedef enum logic [1:0] {
		power_save_off,
		power_save_high,
		power_save_middle,
		power_save_low
	} power_save_level_type;

	// Codes counting from one: zero means one unit
	function automatic logic [7:0] count_plus_one(input logic [6:0] code);
		count_plus_one = {1'b0, code} + 8'h01;
	endfunction

	function automatic power_save_level_type decode_power_save(input logic [1:0] code);
		unique case (code)
			2'h0: decode_power_save = power_save_off;
			2'h1: decode_power_save = power_save_high;
			2'h2: decode_power_save = power_save_middle;
			2'h3: decode_power_save = power_save_low;
		endcase
	endfunction

endpackage

/* config_field_decode.sv */
// Combinational decode of the configuration word into settings
`timescale 1ns/10ps
`include "matrix_driver_common_config_regs.svh"

module config_field_decode (
	// Stored word and mode
	input  wire logic [47:0]                              word_in,
	input  wire logic                                     pwm_forward_in,
	// Decoded settings
	output logic      [5:0]                               device_count_out,
	output logic      [6:0]                               scan_line_count_out,
	output logic      [7:0]                               subperiod_count_out,
	output logic      [4:0]                               multiplier_factor_out,
	output matrix_driver_pkg::power_save_level_type       extended_power_save_level_out,
	output logic      [2:0]                               red_group_delay_out,
	output logic      [2:0]                               green_group_delay_out,
	output logic      [2:0]                               blue_group_delay_out
);

	logic [7:0] device_sum;
	logic [7:0] scan_sum;
	logic [7:0] factor_sum;
	logic [7:0] subp_sum;

	always_comb begin
		device_sum = matrix_driver_pkg::count_plus_one({2'h0, word_in[`CFG_DEVICE_MSB:`CFG_DEVICE_LSB]}); // [R1]
		scan_sum   = matrix_driver_pkg::count_plus_one({1'h0, word_in[`CFG_SCAN_MSB:`CFG_SCAN_LSB]}); // [R6]
		factor_sum = matrix_driver_pkg::count_plus_one({3'h0, word_in[`CFG_FACTOR_MSB:`CFG_FACTOR_LSB]}); // [R9]
		subp_sum   = matrix_driver_pkg::count_plus_one({4'h0, word_in[`CFG_SUBP_MSB:`CFG_SUBP_LSB]});
		device_count_out      = device_sum[5:0];
		scan_line_count_out   = scan_sum[6:0];
		multiplier_factor_out = factor_sum[4:0];
		// Product stays within eight bits, largest is 128
		subperiod_count_out   = 8'((subp_sum * `CFG_SUBP_STEP)); // [R7]
		extended_power_save_level_out =
			matrix_driver_pkg::decode_power_save(word_in[`CFG_EXT_PS_MSB:`CFG_EXT_PS_LSB]); // [R4]
		// Group delays only act in forward PWM mode
		red_group_delay_out   = pwm_forward_in ? word_in[`CFG_RED_DLY_MSB:`CFG_RED_DLY_LSB] : 3'h0; // [R10]
		green_group_delay_out = pwm_forward_in ? word_in[`CFG_GREEN_DLY_MSB:`CFG_GREEN_DLY_LSB] : 3'h0; // [R11]
		blue_group_delay_out  = pwm_forward_in ? word_in[`CFG_BLUE_DLY_MSB:`CFG_BLUE_DLY_LSB] : 3'h0; // [R12]
	end

endmodule

/* memory_line_counter.sv */
// Channel and line counters for storing one frame of grayscale data
`timescale 1ns/10ps
`include "matrix_driver_common_config_regs.svh"

module memory_line_counter #(
	parameter int CHANNELS_PER_LINE = `CFG_CHANNELS_PER_LINE
) (
	// Clock, reset, enable
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       ce_in,
	// Frame control
	input  wire logic       vsync_in,
	input  wire logic       gs_write_in,
	input  wire logic [5:0] last_line_in,
	// Counter state
	output logic      [3:0] channel_q_out,
	output logic      [5:0] line_q_out,
	output logic            frame_stored_q_out
);

	localparam logic [3:0] LAST_CHANNEL = 4'(CHANNELS_PER_LINE - 1);

	logic end_of_line;

	assign end_of_line = (channel_q_out == LAST_CHANNEL);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			channel_q_out <= 4'h0;
		end else if (ce_in) begin
			if (vsync_in || (gs_write_in && end_of_line)) begin
				channel_q_out <= 4'h0;
			end else if (gs_write_in) begin
				channel_q_out <= channel_q_out + 4'h1;
			end
		end
	end

	// Wrap once the last configured line is filled
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			line_q_out         <= 6'h00;
			frame_stored_q_out <= 1'b0;
		end else if (ce_in) begin
			frame_stored_q_out <= 1'b0;
			if (vsync_in) begin
				line_q_out <= 6'h00;
			end else if (gs_write_in && end_of_line) begin
				if (line_q_out >= last_line_in) begin
					line_q_out         <= 6'h00; // [R15]
					frame_stored_q_out <= 1'b1; // [R15]
				end else begin
					line_q_out <= line_q_out + 6'h01;
				end
			end
		end
	end

endmodule

/* matrix_driver_common_config.sv */
// Common configuration word, command handling and decoded settings
`timescale 1ns/10ps
`include "matrix_driver_common_config_regs.svh"

module matrix_driver_common_config #(
	parameter int CHANNELS_PER_LINE = `CFG_CHANNELS_PER_LINE
) (
	// Clock, reset, enable
	input  wire logic                                clk_in,
	input  wire logic                                reset_in,
	input  wire logic                                ce_in,
	// Command words from the serial front end
	input  wire logic                                cmd_valid_in,
	input  wire logic [15:0]                         cmd_id_in,
	input  wire logic [47:0]                         cmd_data_in,
	// Read answer
	output logic                                     rd_valid_out,
	output logic      [47:0]                         rd_data_out,
	// Mode and frame control
	input  wire logic                                pwm_forward_in,
	input  wire logic                                vsync_in,
	input  wire logic                                gs_write_in,
	// Stored word
	output logic      [47:0]                         common_config_word_zero_out,
	// Decoded settings
	output logic      [5:0]                          device_count_out,
	output logic                                     predischarge_enable_out,
	output logic                                     power_save_enable_out,
	output matrix_driver_pkg::power_save_level_type  extended_power_save_level_out,
	output logic                                     open_led_removal_enable_out,
	output logic      [6:0]                          scan_line_count_out,
	output logic      [7:0]                          subperiod_count_out,
	output logic                                     multiplier_range_select_out,
	output logic      [4:0]                          multiplier_factor_out,
	output logic      [2:0]                          red_group_delay_out,
	output logic      [2:0]                          green_group_delay_out,
	output logic      [2:0]                          blue_group_delay_out,
	output logic                                     short_caterpillar_removal_enable_out,
	// Memory write position
	output logic      [3:0]                          channel_index_out,
	output logic      [5:0]                          line_index_out,
	output logic                                     frame_stored_out
);

	logic [47:0]                             word_q;
	logic [47:0]                             word_d;
	logic                                    cmd_write;
	logic                                    cmd_read;
	logic                                    cmd_soft_reset;
	logic [5:0]                              device_count_d;
	logic [6:0]                              scan_line_count_d;
	logic [7:0]                              subperiod_count_d;
	logic [4:0]                              multiplier_factor_d;
	matrix_driver_pkg::power_save_level_type ext_level_d;
	logic [2:0]                              red_delay_d;
	logic [2:0]                              green_delay_d;
	logic [2:0]                              blue_delay_d;

	assign cmd_write      = cmd_valid_in && (cmd_id_in == `CFG_CMD_WRITE);
	assign cmd_read       = cmd_valid_in && (cmd_id_in == `CFG_CMD_READ);
	assign cmd_soft_reset = cmd_valid_in && (cmd_id_in == `CFG_CMD_SOFT_RESET);

	// Only writable bits take new data; reserved bits keep their fixed value
	always_comb begin
		word_d = word_q;
		if (cmd_soft_reset) begin
			word_d = `CFG_RESET_VALUE; // [R14]
		end else if (cmd_write) begin
			word_d = (cmd_data_in & `CFG_WRITE_MASK) | (`CFG_RESET_VALUE & ~`CFG_WRITE_MASK); // [R16]
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			word_q <= `CFG_RESET_VALUE;
		end else if (ce_in) begin
			word_q <= word_d;
		end
	end

	// Read answer reflects the word before a same-cycle update
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= 48'h0000_0000_0000;
		end else if (ce_in) begin
			rd_valid_out <= cmd_read;
			if (cmd_read) begin
				rd_data_out <= word_q; // [R16]
			end
		end
	end

	config_field_decode u_decode (
		.word_in                       (word_q),
		.pwm_forward_in                (pwm_forward_in),
		.device_count_out              (device_count_d),
		.scan_line_count_out           (scan_line_count_d),
		.subperiod_count_out           (subperiod_count_d),
		.multiplier_factor_out         (multiplier_factor_d),
		.extended_power_save_level_out (ext_level_d),
		.red_group_delay_out           (red_delay_d),
		.green_group_delay_out         (green_delay_d),
		.blue_group_delay_out          (blue_delay_d)
	);

	// Registered so the engines see glitch-free settings
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			common_config_word_zero_out          <= `CFG_RESET_VALUE;
			device_count_out                     <= 6'h08;
			predischarge_enable_out              <= 1'b1;
			power_save_enable_out                <= 1'b0;
			extended_power_save_level_out        <= matrix_driver_pkg::power_save_off;
			open_led_removal_enable_out          <= 1'b0;
			scan_line_count_out                  <= 7'h01;
			subperiod_count_out                  <= 8'h10;
			multiplier_range_select_out          <= 1'b0;
			multiplier_factor_out                <= 5'h08;
			red_group_delay_out                  <= 3'h0;
			green_group_delay_out                <= 3'h0;
			blue_group_delay_out                 <= 3'h0;
			short_caterpillar_removal_enable_out <= 1'b0;
		end else if (ce_in) begin
			common_config_word_zero_out          <= word_q;
			device_count_out                     <= device_count_d; // [R1]
			predischarge_enable_out              <= word_q[`CFG_PREDISCHARGE_BIT]; // [R2]
			power_save_enable_out                <= word_q[`CFG_POWER_SAVE_BIT]; // [R3]
			extended_power_save_level_out        <= ext_level_d; // [R4]
			open_led_removal_enable_out          <= word_q[`CFG_OPEN_RM_BIT]; // [R5]
			scan_line_count_out                  <= scan_line_count_d; // [R6]
			subperiod_count_out                  <= subperiod_count_d; // [R7]
			multiplier_range_select_out          <= word_q[`CFG_RANGE_BIT]; // [R8]
			multiplier_factor_out                <= multiplier_factor_d; // [R9]
			red_group_delay_out                  <= red_delay_d; // [R10]
			green_group_delay_out                <= green_delay_d; // [R11]
			blue_group_delay_out                 <= blue_delay_d; // [R12]
			short_caterpillar_removal_enable_out <= word_q[`CFG_SHORT_RM_BIT]; // [R13]
		end
	end

	// Counter is not configuration, so soft reset leaves it alone
	memory_line_counter #(
		.CHANNELS_PER_LINE (CHANNELS_PER_LINE)
	) u_lines (
		.clk_in             (clk_in),
		.reset_in           (reset_in),
		.ce_in              (ce_in),
		.vsync_in           (vsync_in),
		.gs_write_in        (gs_write_in),
		.last_line_in       (word_q[`CFG_SCAN_MSB:`CFG_SCAN_LSB]),
		.channel_q_out      (channel_index_out),
		.line_q_out         (line_index_out),
		.frame_stored_q_out (frame_stored_out)
	);

endmodule

/* matrix_driver_common_config_properties.sv */
// Port checker for the common configuration block
`timescale 1ns/10ps
`include "matrix_driver_common_config_regs.svh"

module config_checker #(
	parameter int CHANNELS_PER_LINE = 16
) (
	// Clock, reset, commands
	input wire logic                                   clk_in,
	input wire logic                                   reset_in,
	input wire logic                                   ce_in,
	input wire logic                                   cmd_valid_in,
	input wire logic [15:0]                            cmd_id_in,
	input wire logic                                   pwm_forward_in,
	// Watched outputs
	input wire logic [47:0]                            common_config_word_zero_out,
	input wire logic [5:0]                             device_count_out,
	input wire matrix_driver_pkg::power_save_level_type extended_power_save_level_out,
	input wire logic [6:0]                             scan_line_count_out,
	input wire logic [7:0]                             subperiod_count_out,
	input wire logic [4:0]                             multiplier_factor_out,
	input wire logic [2:0]                             red_group_delay_out
);
	wire [47:0] w         = common_config_word_zero_out;
	wire        soft_seen = ce_in && cmd_valid_in && cmd_id_in == `CFG_CMD_SOFT_RESET;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// Decoded settings are registered in step with the stored word copy
	AST_DEVICE_COUNT: assert property (device_count_out == {1'b0, w[4:0]} + 6'h01)
		else $error("device count decode");
	AST_PS_LEVEL: assert property (extended_power_save_level_out == w[14:13])
		else $error("power save level decode");
	AST_SCAN_COUNT: assert property (scan_line_count_out == {1'b0, w[21:16]} + 7'h01)
		else $error("scan line decode");
	AST_SUBPERIODS: assert property (subperiod_count_out == {1'b0, w[24:22], 4'h0} + 8'h10)
		else $error("subperiod decode");
	AST_FACTOR: assert property (multiplier_factor_out == {1'b0, w[32:29]} + 5'h01)
		else $error("multiplier decode");
	AST_RED_DELAY: assert property ($past(ce_in) |->
		red_group_delay_out == ($past(pwm_forward_in) ? w[38:36] : 3'h0))
		else $error("red delay gating");
	AST_SOFT_RESET: assert property ($past(soft_seen, 2) && $past(ce_in) |-> w == `CFG_RESET_VALUE)
		else $error("soft reset value");
	AST_RESERVED: assert property ((w & ~`CFG_WRITE_MASK) == 48'h2000_0000_0000)
		else $error("reserved bits");
endmodule

bind matrix_driver_common_config config_checker #(.CHANNELS_PER_LINE(CHANNELS_PER_LINE)) checker_inst (
	.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_id_in(cmd_id_in),
	.pwm_forward_in(pwm_forward_in), .common_config_word_zero_out(common_config_word_zero_out),
	.device_count_out(device_count_out), .extended_power_save_level_out(extended_power_save_level_out),
	.scan_line_count_out(scan_line_count_out), .subperiod_count_out(subperiod_count_out),
	.multiplier_factor_out(multiplier_factor_out), .red_group_delay_out(red_group_delay_out));

/* controller_model.sv */
// Display controller model issuing command words
`timescale 1ns/10ps

module controller_model (
	// Clock
	input  wire logic        clk_in,
	// Command words
	output logic             cmd_valid_out,
	output logic      [15:0] cmd_id_out,
	output logic      [47:0] cmd_data_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_id_out = 16'h0000;
		cmd_data_out = 48'h0000_0000_0000;
	end
	// Back to back calls keep valid high, one command per edge
	task automatic send(input logic [15:0] id, input logic [47:0] data);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_id_out <= id;
		cmd_data_out <= data;
	endtask
	// Inverted lines after release so stale values never look fresh
	task automatic idle;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		cmd_id_out <= ~cmd_id_out;
		cmd_data_out <= ~cmd_data_out;
	endtask
endmodule

/* tb_matrix_driver_common_config.sv */
// Self-checking bench for the common configuration block
`timescale 1ns/10ps
`include "matrix_driver_common_config_regs.svh"
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("MISMATCH %0t %h %h", $time, (g), (e)); \
	end \
end

module tb_matrix_driver_common_config;
	logic        clk_in   = 1'b0;
	logic        reset_in = 1'b1;
	logic        ce_in    = 1'b1;
	logic        pwm_in   = 1'b0;
	logic        vsync_in = 1'b0;
	logic        gs_in    = 1'b0;
	wire         cmd_valid;
	wire  [15:0] cmd_id;
	wire  [47:0] cmd_data;
	wire         rd_valid;
	wire  [47:0] rd_data;
	wire  [47:0] word;
	wire  [5:0]  dev;
	wire  [5:0]  line;
	wire  [6:0]  scan;
	wire  [4:0]  flg;
	wire  [7:0]  subp;
	wire  [4:0]  fac;
	wire  [3:0]  chan;
	wire  [2:0]  red;
	wire  [2:0]  grn;
	wire  [2:0]  blu;
	wire         frame;
	matrix_driver_pkg::power_save_level_type lvl;
	int          n_fail      = 0;
	int          comparisons = 0;

	always #5 clk_in = ~clk_in;

	controller_model ctl (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_id_out(cmd_id), .cmd_data_out(cmd_data));

	matrix_driver_common_config dut (
		.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid), .cmd_id_in(cmd_id),
		.cmd_data_in(cmd_data), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .pwm_forward_in(pwm_in),
		.vsync_in(vsync_in), .gs_write_in(gs_in), .common_config_word_zero_out(word), .device_count_out(dev),
		.predischarge_enable_out(flg[0]), .power_save_enable_out(flg[1]), .extended_power_save_level_out(lvl),
		.open_led_removal_enable_out(flg[2]), .scan_line_count_out(scan), .subperiod_count_out(subp),
		.multiplier_range_select_out(flg[3]), .multiplier_factor_out(fac), .red_group_delay_out(red),
		.green_group_delay_out(grn), .blue_group_delay_out(blu), .short_caterpillar_removal_enable_out(flg[4]),
		.channel_index_out(chan), .line_index_out(line), .frame_stored_out(frame));

	task automatic expect_word(input logic [47:0] d);
		logic [47:0] w;
		w = (d & `CFG_WRITE_MASK) | 48'h2000_0000_0000;
		`CHK(word, w)
		`CHK(dev, {1'b0, w[4:0]} + 6'h01)
		`CHK(flg, {w[47], w[28], w[15], w[12], w[8]})
		`CHK(lvl, w[14:13])
		`CHK(scan, {1'b0, w[21:16]} + 7'h01)
		`CHK(subp, {1'b0, w[24:22], 4'h0} + 8'h10)
		`CHK(fac, {1'b0, w[32:29]} + 5'h01)
		`CHK(red, pwm_in ? w[38:36] : 3'h0)
		`CHK(grn, pwm_in ? w[41:39] : 3'h0)
		`CHK(blu, pwm_in ? w[44:42] : 3'h0)
	endtask

	task automatic wr(input logic [47:0] d);
		ctl.send(`CFG_CMD_WRITE, d);
		ctl.idle();
		@(posedge clk_in);
		#1;
	endtask

	task automatic test_fields;
		logic [47:0] tbl [4] = '{48'hFFFF_FFFF_FFFF, 48'h0, 48'h5A5A_5A5A_5A5A, 48'hA5A5_A5A5_A5A5};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in) pwm_in <= i[0];
			wr(tbl[i]);
			expect_word(tbl[i]);
		end
		$display("fields done");
	endtask

	// Read right behind a write must see the new word
	task automatic test_read;
		ctl.send(`CFG_CMD_WRITE, 48'hFFFF_FFFF_FFFF);
		ctl.send(`CFG_CMD_READ, 48'h0);
		ctl.idle();
		#1;
		`CHK(rd_valid, 1'b1)
		`CHK(rd_data, `CFG_WRITE_MASK | 48'h2000_0000_0000)
		@(posedge clk_in);
		#1;
		`CHK(rd_valid, 1'b0)
		ctl.send(16'hAA01, 48'h0);
		ctl.idle();
		@(posedge clk_in);
		#1;
		expect_word(48'hFFFF_FFFF_FFFF);
		ctl.send(`CFG_CMD_SOFT_RESET, 48'h0);
		ctl.idle();
		@(posedge clk_in);
		#1;
		expect_word(`CFG_RESET_VALUE);
		$display("read and soft reset done");
	endtask

	task automatic test_ce;
		@(posedge clk_in) ce_in <= 1'b0;
		wr(48'h0);
		@(posedge clk_in) ce_in <= 1'b1;
		@(posedge clk_in);
		#1;
		expect_word(`CFG_RESET_VALUE);
		// Reset must win over a low enable
		wr(48'hFFFF_FFFF_FFFF);
		@(posedge clk_in) begin
			ce_in    <= 1'b0;
			reset_in <= 1'b1;
		end
		@(posedge clk_in) begin
			ce_in    <= 1'b1;
			reset_in <= 1'b0;
		end
		@(posedge clk_in);
		#1;
		expect_word(`CFG_RESET_VALUE);
		$display("clock enable done");
	endtask

	// Two scan lines, so the wrap comes on the 32nd write
	task automatic test_frame;
		wr(48'h0000_0001_0000);
		@(posedge clk_in) vsync_in <= 1'b1;
		@(posedge clk_in) vsync_in <= 1'b0;
		gs_in <= 1'b1;
		repeat (31) @(posedge clk_in);
		#1;
		`CHK({frame, line, chan}, {1'b0, 6'h01, 4'hF})
		@(posedge clk_in) gs_in <= 1'b0;
		#1;
		`CHK({frame, line, chan}, {1'b1, 6'h00, 4'h0})
		@(posedge clk_in);
		#1;
		`CHK(frame, 1'b0)
		$display("frame done");
	endtask

	task automatic summarize;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		#1;
		expect_word(`CFG_RESET_VALUE);
		$display("reset done");
		test_fields;
		test_read;
		test_ce;
		test_frame;
		summarize;
	end

	initial begin
		#20000;
		n_fail++;
		summarize;
	end
endmodule
